// ===== hdl/motor_cfg_regs.svh
/*
  Register addresses, reset values, masks and timing counts for the
  motor drive configuration register bank.
  Assumes a 40 MHz core clock and 8-bit register addresses.
*/
`ifndef MOTOR_CFG_REGS_SVH
`define MOTOR_CFG_REGS_SVH

`define SPD_CFG_ADDR      8'h95
`define TIM_CFG_ADDR      8'h96
`define SPD_CFG_RESET     16'h0000
`define TIM_CFG_RESET     16'h0000
// Bit 7 of the timing register is reserved and never stored
`define TIM_CFG_RW_MASK   16'hFF7F

`define CLK_FREQ_KHZ      40000
`define CLK_PERIOD_NS     25
`define SW_LO_KHZ         25
`define SW_HI_KHZ         50
`define SW_LO_CYC         (`CLK_FREQ_KHZ / `SW_LO_KHZ)
`define SW_HI_CYC         (`CLK_FREQ_KHZ / `SW_HI_KHZ)
`define DEAD_STEP_NS      40

`define KT_HIGH_LO_Q4     4'h6
`define KT_HIGH_HI_Q4     4'h8
`define KT_LOW_LO_Q4      4'h3
`define KT_LOW_HI_Q4      4'h2

// Milli-supply-volts per second: 48000, 770, 370, 190, 91, 45
`define ACCEL_FAST_MVCC   16'hBB80
`define ACCEL_C3_MVCC     16'h0302
`define ACCEL_C4_MVCC     16'h0172
`define ACCEL_C5_MVCC     16'h00BE
`define ACCEL_C6_MVCC     16'h005B
`define ACCEL_C7_MVCC     16'h002D

// Typical slew in V/us: 35, 50, 80, 120
`define SLEW_C0_VUS       8'h23
`define SLEW_C1_VUS       8'h32
`define SLEW_C2_VUS       8'h50
`define SLEW_C3_VUS       8'h78

`define ADVANCE_STEP_DEG  8'h1E
`define SENSE_C1_MA       12'h190
`define SENSE_STEP_MA     12'h0C8
`define SENSE_C0_HZ       7'h0C
`define SENSE_C1_HZ       7'h18
`define SENSE_C2_HZ       7'h2F
`define SENSE_C3_HZ       7'h5F
`define SENSE_C0_NS       12'hA00
`define SENSE_C1_NS       12'h500
`define SENSE_C2_NS       12'h280
`define SENSE_C3_NS       12'h140
`define HANDOVER_R1_SHIFT 4

// Duty in tenths of a percent
`define DUTY_CUT          10'h00F
`define DUTY_FLOOR_LO     10'h032
`define DUTY_FLOOR_HI     10'h064
`define DUTY_FULL         10'h3E8

`endif

// ===== hdl/motor_cfg_pkg.sv
/*
  Types for the motor drive configuration register bank.
  Field layouts follow the two 16-bit configuration words, MSB first.
*/
package motor_cfg_pkg;

  typedef struct packed {
    logic       speed_input_type;
    logic       output_switch_rate_sel;
    logic [1:0] torque_const_lock_limits;
    logic       inductive_surge_guard_on;
    logic       mechanical_surge_guard_on;
    logic       mechanical_surge_guard_ref;
    logic       sense_release_behaviour;
    logic       handover_inhibit;
    logic [2:0] loop_accel_rate;
    logic [1:0] min_duty_clamp;
    logic [1:0] edge_rate_select;
  } spd_cfg_type;

  typedef struct packed {
    logic [1:0] sense_advance_angle;
    logic [3:0] sense_current_limit;
    logic [1:0] sense_clock_rate;
    logic       reserved;
    logic [1:0] loop_gain_constant;
    logic [4:0] switch_gap_delay;
  } tim_cfg_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic        rvalid;
    logic [15:0] rdata;
  } reg_rsp_type;

  typedef enum logic [1:0] {
    LOOP_IDLE   = 2'b00,
    LOOP_OPEN   = 2'b01,
    LOOP_CLOSED = 2'b10
  } loop_state_type;

  typedef struct packed {
    logic        speed_pwm_input;
    logic [10:0] switch_period;
    logic [3:0]  kt_high_q4;
    logic [3:0]  kt_low_q4;
    logic        inductive_guard;
    logic        mech_guard;
    logic        mech_ref_fixed;
    logic        release_hiz;
    logic        accel_immediate;
    logic [15:0] accel_mvcc_s;
    logic [1:0]  edge_rate;
    logic [7:0]  slew_v_us;
    logic [7:0]  advance_deg;
    logic        sense_enable;
    logic [11:0] sense_ma;
    logic [6:0]  sense_hz;
    logic [11:0] sense_res_ns;
    logic [2:0]  gain_q4;
    logic [6:0]  dead_cycles;
    logic        closed_loop;
  } settings_type;

  typedef struct packed {
    spd_cfg_type    spd;
    tim_cfg_type    tim;
    reg_rsp_type    rsp;
    settings_type   set;
    loop_state_type loop;
  } state_type;

  typedef struct packed {
    logic [9:0] duty;
  } duty_state_type;

endpackage

// ===== hdl/duty_clamp.sv
/*
  Minimum duty-cycle clamp applied to the commanded duty.
  Assumes duty command in tenths of a percent from logic on core_clk.
*/
`timescale 1ns/1ps
`include "motor_cfg_regs.svh"

module duty_clamp
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] clamp_mode,
  input  wire logic [9:0] duty_cmd,
  output logic      [9:0] duty_out
);

  motor_cfg_pkg::duty_state_type st_q;
  motor_cfg_pkg::duty_state_type st_d;
  logic [9:0]                    floor_val;

  always_comb
  begin
    st_d      = st_q;
    floor_val = clamp_mode[0] ? `DUTY_FLOOR_HI : `DUTY_FLOOR_LO;
    if (duty_cmd < `DUTY_CUT)
      st_d.duty = clamp_mode[1] ? `DUTY_FULL : 10'h000;
    else if (duty_cmd < floor_val)
      st_d.duty = floor_val;
    else
      st_d.duty = duty_cmd;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign duty_out = st_q.duty;

  a_duty_low_cut : assert property (@(posedge core_clk) disable iff (!rstn)
    (duty_cmd < `DUTY_CUT) |=> (duty_out == ($past(clamp_mode[1]) ? `DUTY_FULL : 10'h000)))
    else $error("duty below cut not forced to end value");

endmodule // duty_clamp

// ===== hdl/motor_drive_config_regs.sv
/*
  Two 16-bit motor drive configuration registers with their decoded
  settings, open-to-closed loop handover and the minimum duty clamp.
  Assumes the serial interface engine delivers register requests on
  core_clk as single-cycle strobes, and that speed and duty inputs come
  from logic on the same clock.
*/
// Summary of operation
// - Speed-type bit selects analog level (0) or PWM waveform (1) on speed pin.
// - Switch-rate bit selects 25 kHz when clear, 50 kHz when set.
// - Lock limits: bit 0 high limit 3/2 or 2, bit 1 low 3/4 or 1/2.
// - Inductive surge guard active only while its enable bit is high.
// - Mechanical surge guard active only while its enable bit is high.
// - Mechanical guard clamps to supply (0) or fixed 24 V (1).
// - After sensing, release brakes phases (0) or floats them (1).
// - Inhibit 0 hands over at threshold speed; inhibit 1 stays open loop.
// - Accel code 000 immediate; others 48, 48, 0.77 down to 0.045 Vcc/s.
// - Duty follows command to 5/10% floor, below 1.5% gives 0 or 100%.
// - Two-bit edge rate, slowest at 00, fastest at 11.
// - Advance angle 30, 60, 90 or 120 degrees for codes 00 to 11.
// - Current code 0 disables sensing; 1 is 0.4 A; n is 0.2 A times (n+1).
// - Sense clock 12, 24, 47, 95 Hz with 2.56 down to 0.32 us resolution.
// - Loop gain constant 0.25, 0.5, 0.75 or 1 for codes 00 to 11.
// - Dead time is (n+1) times 40 ns, 40 ns to 1.28 us.
// - Timing register at address 0x96, zero after reset.
// - Handover threshold n x 0.8 Hz, or (n+1) x 12.8 Hz when top bit set.
`timescale 1ns/1ps
`include "motor_cfg_regs.svh"

module motor_drive_config_regs
#(
  parameter int SPEED_W = 12
)
(
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire motor_cfg_pkg::reg_req_type  req,
  output motor_cfg_pkg::reg_rsp_type       rsp,
  input  wire logic                        spin_active,
  input  wire logic [SPEED_W-1:0]          speed_est,
  input  wire logic [4:0]                  handover_speed_threshold,
  input  wire logic [9:0]                  duty_cmd,
  output motor_cfg_pkg::settings_type      settings,
  output logic      [9:0]                  duty_out
);

  // Speed estimate is in 0.8 Hz steps; the top threshold needs nine bits
  if (SPEED_W < 10 || SPEED_W > 16)
  begin : g_bad_speed_w
    $error("SPEED_W must lie between 10 and 16");
  end

  localparam motor_cfg_pkg::state_type STATE_RESET = '{
    spd:  motor_cfg_pkg::spd_cfg_type'(`SPD_CFG_RESET),
    tim:  motor_cfg_pkg::tim_cfg_type'(`TIM_CFG_RESET),
    rsp:  '0,
    set:  '0,
    loop: motor_cfg_pkg::LOOP_IDLE
  };

  motor_cfg_pkg::state_type st_q;
  motor_cfg_pkg::state_type st_d;
  logic [8:0]               thr_steps;
  logic                     thr_reached;

  function automatic logic [15:0] read_word(input logic [7:0]                addr,
                                            input motor_cfg_pkg::spd_cfg_type spd,
                                            input motor_cfg_pkg::tim_cfg_type tim);
    logic [15:0] w;
    w = 16'h0000;
    if (addr == `SPD_CFG_ADDR)
      w = spd;
    else if (addr == `TIM_CFG_ADDR)
      w = tim & `TIM_CFG_RW_MASK;
    return w;
  endfunction

  function automatic logic [15:0] accel_rate(input logic [2:0] code);
    logic [15:0] r;
    case (code)
      3'h0:    r = 16'h0000;
      3'h1:    r = `ACCEL_FAST_MVCC;
      3'h2:    r = `ACCEL_FAST_MVCC;
      3'h3:    r = `ACCEL_C3_MVCC;
      3'h4:    r = `ACCEL_C4_MVCC;
      3'h5:    r = `ACCEL_C5_MVCC;
      3'h6:    r = `ACCEL_C6_MVCC;
      default: r = `ACCEL_C7_MVCC;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] slew_rate(input logic [1:0] code);
    logic [7:0] r;
    case (code)
      2'h0:    r = `SLEW_C0_VUS;
      2'h1:    r = `SLEW_C1_VUS;
      2'h2:    r = `SLEW_C2_VUS;
      default: r = `SLEW_C3_VUS;
    endcase
    return r;
  endfunction

  function automatic logic [6:0] sense_rate(input logic [1:0] code);
    logic [6:0] r;
    case (code)
      2'h0:    r = `SENSE_C0_HZ;
      2'h1:    r = `SENSE_C1_HZ;
      2'h2:    r = `SENSE_C2_HZ;
      default: r = `SENSE_C3_HZ;
    endcase
    return r;
  endfunction

  function automatic logic [11:0] sense_res(input logic [1:0] code);
    logic [11:0] r;
    case (code)
      2'h0:    r = `SENSE_C0_NS;
      2'h1:    r = `SENSE_C1_NS;
      2'h2:    r = `SENSE_C2_NS;
      default: r = `SENSE_C3_NS;
    endcase
    return r;
  endfunction

  function automatic logic [11:0] sense_current(input logic [3:0] code);
    logic [11:0] r;
    if (code == 4'h0)
      r = 12'h000;
    else if (code == 4'h1)
      r = `SENSE_C1_MA;
    else
      r = 12'(({8'h00, code} + 12'h001) * `SENSE_STEP_MA);
    return r;
  endfunction

  // Least time, so the count rounds up: code 0 still gives two cycles
  function automatic logic [6:0] dead_cycles(input logic [4:0] code);
    int ns;
    ns = (int'(code) + 1) * `DEAD_STEP_NS;
    return 7'((ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  endfunction

  // Threshold in 0.8 Hz steps; zero means no valid threshold
  function automatic logic [8:0] handover_steps(input logic [4:0] code);
    logic [8:0] r;
    if (!code[4])
      r = {5'h00, code[3:0]};
    else
      r = 9'(({5'h00, code[3:0]} + 9'h001) << `HANDOVER_R1_SHIFT);
    return r;
  endfunction

  always_comb
  begin
    thr_steps   = handover_steps(handover_speed_threshold);
    thr_reached = (thr_steps != 9'h000) &&
                  (speed_est >= {{(SPEED_W-9){1'b0}}, thr_steps});
  end

  always_comb
  begin
    st_d = st_q;
    st_d.rsp.rvalid = 1'b0;

    if (req.wr)
    begin
      if (req.addr == `SPD_CFG_ADDR)
        st_d.spd = motor_cfg_pkg::spd_cfg_type'(req.wdata);
      else if (req.addr == `TIM_CFG_ADDR)
        st_d.tim = motor_cfg_pkg::tim_cfg_type'(req.wdata & `TIM_CFG_RW_MASK);
    end

    // Reads see the word as it stood before a same-cycle write
    if (req.rd)
    begin
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rdata  = read_word(req.addr, st_q.spd, st_q.tim);
    end

    case (st_q.loop)
      motor_cfg_pkg::LOOP_IDLE:
        if (spin_active)
          st_d.loop = motor_cfg_pkg::LOOP_OPEN;
      motor_cfg_pkg::LOOP_OPEN:
        if (!spin_active)
          st_d.loop = motor_cfg_pkg::LOOP_IDLE;
        else if (!st_q.spd.handover_inhibit && thr_reached)
          st_d.loop = motor_cfg_pkg::LOOP_CLOSED;
      motor_cfg_pkg::LOOP_CLOSED:
        if (!spin_active)
          st_d.loop = motor_cfg_pkg::LOOP_IDLE;
        else if (st_q.spd.handover_inhibit)
          st_d.loop = motor_cfg_pkg::LOOP_OPEN;
      default:
        st_d.loop = motor_cfg_pkg::LOOP_IDLE;
    endcase

    st_d.set.speed_pwm_input = st_q.spd.speed_input_type;
    st_d.set.switch_period   = st_q.spd.output_switch_rate_sel ?
                               11'(`SW_HI_CYC) : 11'(`SW_LO_CYC);
    st_d.set.kt_high_q4      = st_q.spd.torque_const_lock_limits[0] ?
                               `KT_HIGH_HI_Q4 : `KT_HIGH_LO_Q4;
    st_d.set.kt_low_q4       = st_q.spd.torque_const_lock_limits[1] ?
                               `KT_LOW_HI_Q4 : `KT_LOW_LO_Q4;
    st_d.set.inductive_guard = st_q.spd.inductive_surge_guard_on;
    st_d.set.mech_guard      = st_q.spd.mechanical_surge_guard_on;
    // Reference only matters while the mechanical guard is on
    st_d.set.mech_ref_fixed  = st_q.spd.mechanical_surge_guard_on &&
                               st_q.spd.mechanical_surge_guard_ref;
    st_d.set.release_hiz     = st_q.spd.sense_release_behaviour;
    st_d.set.accel_immediate = (st_q.spd.loop_accel_rate == 3'h0);
    st_d.set.accel_mvcc_s    = accel_rate(st_q.spd.loop_accel_rate);
    st_d.set.edge_rate       = st_q.spd.edge_rate_select;
    st_d.set.slew_v_us       = slew_rate(st_q.spd.edge_rate_select);
    st_d.set.advance_deg     = 8'(({6'h00, st_q.tim.sense_advance_angle} + 8'h01) *
                                  `ADVANCE_STEP_DEG);
    st_d.set.sense_enable    = (st_q.tim.sense_current_limit != 4'h0);
    st_d.set.sense_ma        = sense_current(st_q.tim.sense_current_limit);
    st_d.set.sense_hz        = sense_rate(st_q.tim.sense_clock_rate);
    st_d.set.sense_res_ns    = sense_res(st_q.tim.sense_clock_rate);
    st_d.set.gain_q4         = {1'b0, st_q.tim.loop_gain_constant} + 3'h1;
    st_d.set.dead_cycles     = dead_cycles(st_q.tim.switch_gap_delay);
    st_d.set.closed_loop     = (st_d.loop == motor_cfg_pkg::LOOP_CLOSED);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      st_q <= STATE_RESET;
    else
      st_q <= st_d;
  end

  assign rsp      = st_q.rsp;
  assign settings = st_q.set;

  duty_clamp u_duty_clamp
  (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .clamp_mode (st_q.spd.min_duty_clamp),
    .duty_cmd   (duty_cmd),
    .duty_out   (duty_out)
  );

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_spd_write;
    req.wr && (req.addr == `SPD_CFG_ADDR);
  endsequence

  sequence s_tim_write;
    req.wr && (req.addr == `TIM_CFG_ADDR);
  endsequence

  sequence s_quiet;
    !req.wr;
  endsequence

  a_speed_type_follow : assert property (
    s_spd_write ##1 s_quiet |=> settings.speed_pwm_input == $past(req.wdata[15], 2))
    else $error("speed input type not taken from written word");

  a_switch_period_sel : assert property (
    1'b1 |=> settings.switch_period ==
             ($past(st_q.spd.output_switch_rate_sel) ? 11'(`SW_HI_CYC) : 11'(`SW_LO_CYC)))
    else $error("switch period does not match rate select");

  a_kt_limit_pair : assert property (
    1'b1 |=> (settings.kt_high_q4 == ($past(st_q.spd.torque_const_lock_limits[0]) ?
                                      `KT_HIGH_HI_Q4 : `KT_HIGH_LO_Q4)) &&
             (settings.kt_low_q4 == ($past(st_q.spd.torque_const_lock_limits[1]) ?
                                     `KT_LOW_HI_Q4 : `KT_LOW_LO_Q4)))
    else $error("torque constant limits wrong");

  a_surge_guard_en : assert property (
    s_spd_write ##1 s_quiet |=> (settings.inductive_guard == $past(req.wdata[11], 2)) &&
                                (settings.mech_guard == $past(req.wdata[10], 2)) &&
                                (!settings.mech_ref_fixed || settings.mech_guard))
    else $error("surge guard enables do not follow register");

  a_handover_blocked : assert property (
    settings.closed_loop |-> !$past(st_q.spd.handover_inhibit) && $past(spin_active))
    else $error("closed loop entered while handover inhibited");

  a_handover_timely : assert property (
    (st_q.loop == motor_cfg_pkg::LOOP_OPEN) && spin_active && thr_reached &&
    !st_q.spd.handover_inhibit |=> settings.closed_loop)
    else $error("handover not taken at threshold");

  a_accel_immediate : assert property (
    settings.accel_immediate |-> settings.accel_mvcc_s == 16'h0000)
    else $error("immediate accel code carries a rate");

  a_advance_angle : assert property (
    1'b1 |=> settings.advance_deg ==
             8'(({6'h00, $past(st_q.tim.sense_advance_angle)} + 8'h01) * `ADVANCE_STEP_DEG))
    else $error("advance angle wrong");

  a_sense_disable : assert property (
    1'b1 |=> settings.sense_enable == ($past(st_q.tim.sense_current_limit) != 4'h0))
    else $error("sensing enable does not follow current code");

  a_rsvd_reads_zero : assert property (
    s_tim_write |=> !st_q.tim.reserved [*2])
    else $error("reserved timing bit was stored");

  a_dead_time_span : assert property (
    1'b1 |=> (int'(settings.dead_cycles) * `CLK_PERIOD_NS >=
              (int'($past(st_q.tim.switch_gap_delay)) + 1) * `DEAD_STEP_NS) &&
             (int'(settings.dead_cycles) * `CLK_PERIOD_NS <
              (int'($past(st_q.tim.switch_gap_delay)) + 1) * `DEAD_STEP_NS + `CLK_PERIOD_NS))
    else $error("dead time count out of span");

  a_spd_readback : assert property (
    s_spd_write ##1 (req.rd && (req.addr == `SPD_CFG_ADDR) && !req.wr) |=>
      rsp.rvalid && (rsp.rdata == $past(req.wdata, 2)))
    else $error("configuration word did not read back");

  a_tim_readback : assert property (
    s_tim_write ##1 (req.rd && (req.addr == `TIM_CFG_ADDR) && !req.wr) |=>
      rsp.rvalid && (rsp.rdata == ($past(req.wdata, 2) & `TIM_CFG_RW_MASK)))
    else $error("timing word did not read back at its address");

  a_release_follow : assert property (
    s_spd_write ##1 s_quiet |=> settings.release_hiz == $past(req.wdata[8], 2))
    else $error("release behaviour not taken from written word");

  a_edge_rate_follow : assert property (
    s_spd_write ##1 s_quiet |=> settings.edge_rate == $past(req.wdata[1:0], 2))
    else $error("edge rate code not taken from written word");

  a_sense_res_step : assert property (
    s_tim_write ##1 s_quiet |=>
      settings.sense_res_ns == (`SENSE_C0_NS >> $past(req.wdata[9:8], 2)))
    else $error("sense resolution does not halve per clock code");

  a_gain_follow : assert property (
    s_tim_write ##1 s_quiet |=>
      settings.gain_q4 == ({1'b0, $past(req.wdata[6:5], 2)} + 3'h1))
    else $error("loop gain constant not taken from written word");

  a_zero_threshold : assert property (
    (st_q.loop == motor_cfg_pkg::LOOP_OPEN) && (handover_speed_threshold == 5'h00) |=>
      !settings.closed_loop)
    else $error("handover taken with no valid threshold");

endmodule // motor_drive_config_regs

// ===== bench/reg_host_model.sv
/*
  Host model of the register port: single-cycle write and read strobes.
  Assumes the register bank samples the port on rising edges of core_clk.
*/
`timescale 1ns/1ps

module reg_host_model
(
  input  wire logic                       core_clk,
  output motor_cfg_pkg::reg_req_type      req,
  input  wire motor_cfg_pkg::reg_rsp_type rsp
);
  initial
  begin
    req = '0;
  end

  // Released lines show the inverse so a stale value cannot pass
  task automatic drop;
    req.wr    = 1'b0;
    req.rd    = 1'b0;
    req.addr  = ~req.addr;
    req.wdata = ~req.wdata;
  endtask

  task automatic write(input logic [7:0] addr, input logic [15:0] data);
    @(negedge core_clk);
    req.wr    = 1'b1;
    req.addr  = addr;
    req.wdata = (addr == 8'h96) ? (data & 16'hFF7F) : data;
    @(negedge core_clk);
    drop();
  endtask

  task automatic read(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    @(negedge core_clk);
    req.rd   = 1'b1;
    req.addr = addr;
    @(negedge core_clk);
    ok   = rsp.rvalid;
    data = rsp.rdata;
    drop();
  endtask

  // Read on the edge right after the write, to reach the back-to-back path
  task automatic write_read(input logic [7:0] addr, input logic [15:0] data,
                            output logic [15:0] rdata, output logic ok);
    @(negedge core_clk);
    req.wr    = 1'b1;
    req.addr  = addr;
    req.wdata = (addr == 8'h96) ? (data & 16'hFF7F) : data;
    @(negedge core_clk);
    req.wr = 1'b0;
    req.rd = 1'b1;
    @(negedge core_clk);
    ok    = rsp.rvalid;
    rdata = rsp.rdata;
    drop();
  endtask
endmodule // reg_host_model

// ===== bench/motor_drive_config_regs_tb.sv
/*
  Self-checking bench for the configuration register bank.
  Assumes the host model drives the register port on falling edges.
*/
`timescale 1ns/1ps

`define CHECK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
      failures++; \
    end \
  end

module motor_drive_config_regs_tb;
  logic                        core_clk = 1'b0;
  logic                        rstn = 1'b0;
  logic                        spin_active = 1'b0;
  logic [11:0]                 speed_est = 12'h000;
  logic [4:0]                  handover_speed_threshold = 5'h00;
  logic [9:0]                  duty_cmd = 10'h000;
  motor_cfg_pkg::reg_req_type  req;
  motor_cfg_pkg::reg_rsp_type  rsp;
  motor_cfg_pkg::settings_type settings;
  logic [9:0]                  duty_out;
  int                          failures = 0;
  int                          checked = 0;
  logic [15:0]                 rd_data;
  logic                        rd_ok;

  always #12.5 core_clk = ~core_clk;

  motor_drive_config_regs #(.SPEED_W(12)) dut
  (
    .core_clk                 (core_clk),
    .rstn                     (rstn),
    .req                      (req),
    .rsp                      (rsp),
    .spin_active              (spin_active),
    .speed_est                (speed_est),
    .handover_speed_threshold (handover_speed_threshold),
    .duty_cmd                 (duty_cmd),
    .settings                 (settings),
    .duty_out                 (duty_out)
  );

  reg_host_model host (.core_clk(core_clk), .req(req), .rsp(rsp));

  task automatic read_expect(input logic [7:0] addr, input logic [15:0] exp);
    host.read(addr, rd_data, rd_ok);
    `CHECK("rvalid", 1'b1, rd_ok);
    `CHECK("rdata", exp, rd_data);
  endtask

  task automatic check_reset;
    `CHECK("switch_period", 11'h640, settings.switch_period);
    `CHECK("kt_high", 4'h6, settings.kt_high_q4);
    `CHECK("dead_cycles", 7'h02, settings.dead_cycles);
    `CHECK("accel_immediate", 1'b1, settings.accel_immediate);
    read_expect(8'h95, 16'h0000);
    read_expect(8'h96, 16'h0000);
  endtask

  task automatic check_timing_decode;
    logic [3:0]  cur [4] = '{4'h0, 4'h1, 4'hA, 4'hF};
    logic [11:0] ma [4]  = '{12'h000, 12'h190, 12'h898, 12'hC80};
    logic [6:0]  hz [4]  = '{7'h0C, 7'h18, 7'h2F, 7'h5F};
    logic [11:0] res [4] = '{12'hA00, 12'h500, 12'h280, 12'h140};
    logic [4:0]  dt [4]  = '{5'h00, 5'h0A, 5'h14, 5'h1F};
    logic [6:0]  dc [4]  = '{7'h02, 7'h12, 7'h22, 7'h34};
    logic [15:0] w;
    for (int i = 0; i < 4; i++)
    begin
      w = {i[1:0], cur[i], i[1:0], 1'b1, i[1:0], dt[i]};
      host.write(8'h96, w);
      @(negedge core_clk);
      `CHECK("advance_deg", 8'h1E * (i + 1), settings.advance_deg);
      `CHECK("sense_enable", i != 0, settings.sense_enable);
      `CHECK("sense_ma", ma[i], settings.sense_ma);
      `CHECK("sense_hz", hz[i], settings.sense_hz);
      `CHECK("sense_res_ns", res[i], settings.sense_res_ns);
      `CHECK("gain_q4", i + 1, settings.gain_q4);
      `CHECK("dead_cycles", dc[i], settings.dead_cycles);
      read_expect(8'h96, w & 16'hFF7F);
    end
  endtask

  task automatic check_speed_decode;
    logic [15:0] acc [8] = '{16'h0000, 16'hBB80, 16'hBB80, 16'h0302,
                             16'h0172, 16'h00BE, 16'h005B, 16'h002D};
    logic [7:0]  slew [4] = '{8'h23, 8'h32, 8'h50, 8'h78};
    logic [2:0]  b;
    logic [15:0] w;
    for (int i = 0; i < 8; i++)
    begin
      b = i[2:0];
      w = {b[0], b[1], b[1:0], b[0], b[1], b[2], b[2], 1'b0, b, 2'b00, b[1:0]};
      host.write(8'h95, w);
      @(negedge core_clk);
      `CHECK("speed_pwm_input", b[0], settings.speed_pwm_input);
      `CHECK("switch_period", b[1] ? 11'h320 : 11'h640, settings.switch_period);
      `CHECK("kt_high", b[0] ? 4'h8 : 4'h6, settings.kt_high_q4);
      `CHECK("kt_low", b[1] ? 4'h2 : 4'h3, settings.kt_low_q4);
      `CHECK("inductive_guard", b[0], settings.inductive_guard);
      `CHECK("mech_guard", b[1], settings.mech_guard);
      `CHECK("mech_ref_fixed", b[2] & b[1], settings.mech_ref_fixed);
      `CHECK("release_hiz", b[2], settings.release_hiz);
      `CHECK("accel_immediate", i == 0, settings.accel_immediate);
      `CHECK("accel_mvcc_s", acc[i], settings.accel_mvcc_s);
      `CHECK("edge_rate", b[1:0], settings.edge_rate);
      `CHECK("slew_v_us", slew[b[1:0]], settings.slew_v_us);
      read_expect(8'h95, w);
    end
  endtask

  task automatic check_unmapped;
    host.write(8'h95, 16'h1230);
    host.write(8'h40, 16'hFFFF);
    read_expect(8'h95, 16'h1230);
    read_expect(8'h97, 16'h0000);
    host.write_read(8'h95, 16'h5A3C, rd_data, rd_ok);
    `CHECK("rvalid back to back", 1'b1, rd_ok);
    `CHECK("rdata back to back", 16'h5A3C, rd_data);
    host.write_read(8'h96, 16'hC3A5, rd_data, rd_ok);
    `CHECK("rdata back to back", 16'hC325, rd_data);
  endtask

  task automatic check_duty;
    logic [9:0] c [7] = '{10'h00A, 10'h00E, 10'h00F, 10'h031, 10'h032, 10'h063, 10'h258};
    logic [9:0] fl;
    logic [9:0] e;
    for (int m = 0; m < 4; m++)
    begin
      host.write(8'h95, {12'h000, m[1:0], 2'b00});
      fl = m[0] ? 10'h064 : 10'h032;
      for (int k = 0; k < 7; k++)
      begin
        duty_cmd = c[k];
        e = (c[k] < 10'h00F) ? (m[1] ? 10'h3E8 : 10'h000) : ((c[k] < fl) ? fl : c[k]);
        @(negedge core_clk);
        `CHECK("duty_out", e, duty_out);
      end
    end
  endtask

  task automatic check_handover;
    host.write(8'h95, 16'h0000);
    handover_speed_threshold = 5'h03;
    spin_active = 1'b1;
    speed_est = 12'h002;
    repeat (2) @(negedge core_clk);
    `CHECK("closed_loop below", 1'b0, settings.closed_loop);
    speed_est = 12'h003;
    @(negedge core_clk);
    `CHECK("closed_loop at", 1'b1, settings.closed_loop);
    host.write(8'h95, 16'h0080);
    @(negedge core_clk);
    `CHECK("closed_loop inhibit", 1'b0, settings.closed_loop);
    handover_speed_threshold = 5'h10;
    host.write(8'h95, 16'h0000);
    @(negedge core_clk);
    `CHECK("closed_loop range1", 1'b0, settings.closed_loop);
    speed_est = 12'h010;
    @(negedge core_clk);
    `CHECK("closed_loop range1", 1'b1, settings.closed_loop);
    spin_active = 1'b0;
    @(negedge core_clk);
    `CHECK("closed_loop stop", 1'b0, settings.closed_loop);
    handover_speed_threshold = 5'h00;
    spin_active = 1'b1;
    speed_est = 12'hFFF;
    repeat (3) @(negedge core_clk);
    `CHECK("closed_loop zero", 1'b0, settings.closed_loop);
  endtask

  task automatic complete_run;
    $display("Checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole sequence needs about 150 cycles; ample margin
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    complete_run();
  end

  initial
  begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    check_reset();
    check_timing_decode();
    check_speed_decode();
    check_unmapped();
    check_duty();
    check_handover();
    complete_run();
  end
endmodule // motor_drive_config_regs_tb
